//--- core/ssp_pkg.sv
package ssp_pkg;

  // Register byte addresses on the Avalon-MM slave
  localparam logic [5:0] ADDR_RX_STATUS_CONTROL = 6'h00;
  localparam logic [5:0] ADDR_TX_STATUS_CONTROL = 6'h04;
  localparam logic [5:0] ADDR_RECEIVE_DATA = 6'h08;
  localparam logic [5:0] ADDR_TX_HOLDING = 6'h0C;
  localparam logic [5:0] ADDR_INTERRUPT_CONTROL = 6'h10;
  localparam logic [5:0] ADDR_PERIPH_IRQ_ENABLE_1 = 6'h14;
  localparam logic [5:0] ADDR_PERIPH_IRQ_FLAGS_1 = 6'h18;
  localparam logic [5:0] ADDR_BAUD_CONTROL = 6'h1C;
  localparam logic [5:0] ADDR_ALT_PIN_SELECT_0 = 6'h20;
  localparam logic [5:0] ADDR_ALT_PIN_SELECT_1 = 6'h24;

  // receive_status_control bits
  localparam int RCS_PORT_ENABLE = 7;
  localparam int RCS_NINTH_RX_ENABLE = 6;
  localparam int RCS_SINGLE_RX_ENABLE = 5;
  localparam int RCS_CONT_RX_ENABLE = 4;
  localparam int RCS_OVERRUN = 1;
  localparam int RCS_RX_NINTH_BIT = 0;
  // transmit_status_control bits
  localparam int TCS_CLOCK_MASTER = 7;
  localparam int TCS_NINTH_TX_ENABLE = 6;
  localparam int TCS_TX_ENABLE = 5;
  localparam int TCS_SYNC_MODE = 4;
  localparam int TCS_SHIFT_EMPTY = 1;
  localparam int TCS_TX_NINTH_BIT = 0;
  // interrupt_control bits
  localparam int ICN_GLOBAL_ENABLE = 7;
  localparam int ICN_PERIPH_ENABLE = 6;
  // peripheral_irq_enable_1 / peripheral_irq_flags_1 bits
  localparam int PIR_RECEIVE = 5;
  localparam int PIR_TRANSMIT = 4;
  // baud_control bits
  localparam int BDC_RX_IDLE = 6;
  // alt_pin_select bits
  localparam int APS0_DATA_ALT = 7;
  localparam int APS1_CLOCK_ALT = 0;

  // Reset values of the software-written registers
  localparam logic [7:0] RST_RX_STATUS_CONTROL = 8'h00;
  localparam logic [7:0] RST_TX_STATUS_CONTROL = 8'h00;
  localparam logic [7:0] RST_INTERRUPT_CONTROL = 8'h00;
  localparam logic [7:0] RST_PERIPH_IRQ_ENABLE_1 = 8'h00;
  localparam logic [7:0] RST_ALT_PIN_SELECT = 8'h00;

  // Word lengths on the link
  localparam logic [3:0] BITS_SHORT_WORD = 4'h8;
  localparam logic [3:0] BITS_LONG_WORD = 4'h9;

  typedef struct packed {
    logic ninth;
    logic [7:0] data;
  } ssp_word_t;

endpackage

//--- core/ssp_serial_port.sv
// Decided for this implementation: the address map and the Avalon-MM register port.
`timescale 1ns/1ps
// Overview of operation
// [R1] Slave operation when sync mode and port enable set, clock-master select cleared.
// [R2] Ninth-bit receive enable selects 9-bit words, otherwise 8-bit words.
// [R3] Incoming words are accepted only while continuous receive is enabled.
// [R4] Completed word sets receive-complete flag; request raised only if receive interrupt enabled.
// [R5] In 9-bit mode the received ninth bit shows in the status register.
// [R6] Reading receive data returns low eight bits of oldest FIFO word.
// [R7] Overrun clears when continuous receive or port enable is cleared; the latter resets port.
// [R8] During sleep only slave mode shifts; system-clocked modes do not shift.
// [R9] In slave mode both shift registers advance on the external clock.
// [R10] Sleep reception: master drives clock and data pins, port accepts both.
// [R11] Word fully clocked in during sleep sets receive-complete flag, waking processor.
// [R12] Reading receive data unloads words; flag clears once the buffer is empty.
// [R13] After wake, vector to interrupt only if global interrupt enable set.
// [R14] Writing transmit data clears buffer-empty flag, filling shift then holding register. Here a direct load to the shift register leaves it set.
// [R15] Sleep transmission: master clocks the clock pin, port shifts data out.
// [R16] Shift word done: holding byte moves to shift register, buffer-empty flag sets.
// [R17] Transmit wake needs both transmit and peripheral interrupt enables.
// [R18] A new write after the wake clears the buffer-empty flag again.
// [R19] Data and clock pins relocate under the alternate pin select registers.
// [R20] Both receive enables cleared gives transmit mode; receive enable gives receive mode.
// [R21] In slave receive the receiver is never idle; single receive has no effect.
// [R22] Two writes: first goes straight to shift register, second waits in holding.
// [R23] Word completing with full FIFO flags overrun and stops acceptance.
module ssp_serial_port #(
  parameter int RX_FIFO_DEPTH = 2
) (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst,
  // Avalon-MM slave
  input wire logic [5:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  // Processor state and requests
  input wire logic i_sleep,
  output logic o_wake,
  output logic o_vector_req,
  // Serial pins, index 0 default location, index 1 alternate
  input wire logic [1:0] i_serial_clock_pin,
  input wire logic [1:0] i_serial_data_pin,
  output logic [1:0] o_serial_data_pin,
  output logic [1:0] o_serial_data_oe
);

  localparam int PTR_W = (RX_FIFO_DEPTH > 1) ? $clog2(RX_FIFO_DEPTH) : 1;

  // Software registers
  logic [7:0] rx_ctl;
  logic [7:0] tx_ctl;
  logic [7:0] int_ctl;
  logic [7:0] irq_en;
  logic [7:0] alt_sel_0;
  logic [7:0] alt_sel_1;
  logic bus_ack;

  // Link synchronisers, one pair per pin location
  logic [1:0] ck_meta;
  logic [1:0] ck_sync;
  logic ck_prev;
  logic [1:0] dt_meta;
  logic [1:0] dt_sync;

  // Receive path
  ssp_pkg::ssp_word_t rx_fifo [RX_FIFO_DEPTH];
  logic [PTR_W-1:0] rx_wr_ptr;
  logic [PTR_W-1:0] rx_rd_ptr;
  logic [PTR_W:0] rx_count;
  logic [8:0] rx_shift;
  logic [3:0] rx_bits;
  logic overrun;

  // Transmit path
  ssp_pkg::ssp_word_t tx_hold;
  logic tx_hold_valid;
  logic [8:0] tx_shift;
  logic [3:0] tx_bits_left;
  logic tx_long;
  logic tx_hold_long;

  function automatic logic [PTR_W-1:0] ptr_inc(input logic [PTR_W-1:0] p);
    ptr_inc = (p == PTR_W'(RX_FIFO_DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction

  // Mode decode
  wire port_en = rx_ctl[ssp_pkg::RCS_PORT_ENABLE];
  wire port_rst = i_rst | ~port_en;
  wire slave_mode = port_en & tx_ctl[ssp_pkg::TCS_SYNC_MODE]
                  & ~tx_ctl[ssp_pkg::TCS_CLOCK_MASTER]; // [R1]
  // Only the externally clocked slave mode shifts, asleep or awake
  wire shift_en = slave_mode; // [R8]
  wire cont_rx = rx_ctl[ssp_pkg::RCS_CONT_RX_ENABLE];
  wire rx_mode = shift_en & cont_rx; // [R3] [R21]
  wire tx_mode = shift_en & ~cont_rx & ~rx_ctl[ssp_pkg::RCS_SINGLE_RX_ENABLE]
               & tx_ctl[ssp_pkg::TCS_TX_ENABLE]; // [R20]
  wire rx_long = rx_ctl[ssp_pkg::RCS_NINTH_RX_ENABLE];
  wire [3:0] rx_len = rx_long ? ssp_pkg::BITS_LONG_WORD : ssp_pkg::BITS_SHORT_WORD; // [R2]

  // Pin relocation
  wire ck_alt = alt_sel_1[ssp_pkg::APS1_CLOCK_ALT];
  wire dt_alt = alt_sel_0[ssp_pkg::APS0_DATA_ALT];
  // Both locations are synchronised first, so the select never sees a raw pin
  wire ck_sel = ck_sync[ck_alt]; // [R19]
  wire dt_sel = dt_sync[dt_alt]; // [R19]

  // Data is sampled and advanced on the falling clock edge seen in the core domain
  wire ck_fall = ck_prev & ~ck_sel; // [R9]

  // Bus decode
  wire bus_req = i_avs_read | i_avs_write;
  wire bus_fire = bus_req & bus_ack;
  wire wr_fire = bus_fire & i_avs_write & i_avs_byteenable[0];
  wire rd_fire = bus_fire & i_avs_read;
  wire [7:0] wdata = i_avs_writedata[7:0];
  wire wr_rx_ctl = wr_fire & (i_avs_address == ssp_pkg::ADDR_RX_STATUS_CONTROL);
  wire wr_tx_ctl = wr_fire & (i_avs_address == ssp_pkg::ADDR_TX_STATUS_CONTROL);
  wire wr_tx_data = wr_fire & (i_avs_address == ssp_pkg::ADDR_TX_HOLDING);
  wire wr_int_ctl = wr_fire & (i_avs_address == ssp_pkg::ADDR_INTERRUPT_CONTROL);
  wire wr_irq_en = wr_fire & (i_avs_address == ssp_pkg::ADDR_PERIPH_IRQ_ENABLE_1);
  wire wr_alt_0 = wr_fire & (i_avs_address == ssp_pkg::ADDR_ALT_PIN_SELECT_0);
  wire wr_alt_1 = wr_fire & (i_avs_address == ssp_pkg::ADDR_ALT_PIN_SELECT_1);
  wire rd_rx_data = rd_fire & (i_avs_address == ssp_pkg::ADDR_RECEIVE_DATA);

  // Receive FIFO status
  wire rx_empty = (rx_count == '0);
  wire rx_full = (rx_count == (PTR_W + 1)'(RX_FIFO_DEPTH));
  ssp_pkg::ssp_word_t rx_head;
  assign rx_head = rx_fifo[rx_rd_ptr];
  wire rx_complete_flag = ~rx_empty; // [R4] [R11] [R12]
  wire rx_bit_take = rx_mode & ck_fall & ~overrun;
  wire rx_word_done = rx_bit_take & (rx_bits == rx_len - 4'h1);
  wire [8:0] rx_word = {dt_sel, rx_shift[8:1]};
  // LSB first: an 8-bit word lands in the upper 8 bits of the shifter
  wire [8:0] rx_aligned = rx_long ? rx_word : {1'b0, rx_word[8:1]};
  wire rx_push = rx_word_done & ~rx_full;
  wire rx_overflow = rx_word_done & rx_full; // [R23]
  wire rx_pop = rd_rx_data & ~rx_empty; // [R12]

  // Transmit status
  wire tx_busy = (tx_bits_left != 4'h0);
  wire tx_bit_step = tx_mode & tx_busy & ck_fall;
  wire tx_word_done = tx_bit_step & (tx_bits_left == 4'h1);
  wire tx_load_hold = tx_hold_valid & (~tx_busy | tx_word_done); // [R16]
  wire tx_load_direct = wr_tx_data & ~tx_busy & ~tx_hold_valid; // [R14] [R22]
  wire tx_buffer_empty_flag = ~tx_hold_valid; // [R14] [R16] [R18]
  wire tx_wr_long = tx_ctl[ssp_pkg::TCS_NINTH_TX_ENABLE];
  ssp_pkg::ssp_word_t tx_wr_word;
  assign tx_wr_word = '{ninth: tx_ctl[ssp_pkg::TCS_TX_NINTH_BIT], data: wdata};

  // Interrupt requests
  wire rx_req = rx_complete_flag & irq_en[ssp_pkg::PIR_RECEIVE]; // [R4]
  wire tx_req = tx_buffer_empty_flag & irq_en[ssp_pkg::PIR_TRANSMIT]
              & int_ctl[ssp_pkg::ICN_PERIPH_ENABLE]; // [R17]
  wire irq_req = rx_req | tx_req;

  // Read mux
  // An empty buffer reads as zero rather than a stale or unwritten slot
  wire [7:0] rx_head_data = rx_empty ? 8'h00 : rx_head.data;
  wire [7:0] rd_rx_ctl = {rx_ctl[7:2], overrun, rx_head.ninth & rx_long & ~rx_empty}; // [R5] [R7]
  wire [7:0] rd_tx_ctl = {tx_ctl[7:2], ~tx_busy, tx_ctl[0]};
  wire [7:0] rd_flags = {2'b00, rx_complete_flag, tx_buffer_empty_flag, 4'h0};
  wire [7:0] rd_baud = {1'b0, ~rx_mode, 6'h00}; // [R21]
  logic [7:0] rd_mux;
  always_comb begin
    case (i_avs_address)
      ssp_pkg::ADDR_RX_STATUS_CONTROL: rd_mux = rd_rx_ctl;
      ssp_pkg::ADDR_TX_STATUS_CONTROL: rd_mux = rd_tx_ctl;
      ssp_pkg::ADDR_RECEIVE_DATA: rd_mux = rx_head_data; // [R6]
      ssp_pkg::ADDR_INTERRUPT_CONTROL: rd_mux = int_ctl;
      ssp_pkg::ADDR_PERIPH_IRQ_ENABLE_1: rd_mux = irq_en;
      ssp_pkg::ADDR_PERIPH_IRQ_FLAGS_1: rd_mux = rd_flags;
      ssp_pkg::ADDR_BAUD_CONTROL: rd_mux = rd_baud;
      ssp_pkg::ADDR_ALT_PIN_SELECT_0: rd_mux = alt_sel_0;
      ssp_pkg::ADDR_ALT_PIN_SELECT_1: rd_mux = alt_sel_1;
      default: rd_mux = 8'h00;
    endcase
  end

  // One wait state on every access
  assign o_avs_waitrequest = bus_req & ~bus_ack;

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      bus_ack <= 1'b0;
      o_avs_readdata <= 32'h0000_0000;
    end else begin
      bus_ack <= bus_req & ~bus_ack;
      o_avs_readdata <= {24'h000000, rd_mux};
    end
  end

  // Control registers survive a port-enable reset; only i_rst clears them
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      rx_ctl <= ssp_pkg::RST_RX_STATUS_CONTROL;
      tx_ctl <= ssp_pkg::RST_TX_STATUS_CONTROL;
      int_ctl <= ssp_pkg::RST_INTERRUPT_CONTROL;
      irq_en <= ssp_pkg::RST_PERIPH_IRQ_ENABLE_1;
      alt_sel_0 <= ssp_pkg::RST_ALT_PIN_SELECT;
      alt_sel_1 <= ssp_pkg::RST_ALT_PIN_SELECT;
    end else begin
      if (wr_rx_ctl) begin
        rx_ctl <= {wdata[7:2], 2'b00};
      end
      if (wr_tx_ctl) begin
        tx_ctl <= {wdata[7:2], 1'b0, wdata[0]};
      end
      if (wr_int_ctl) begin
        int_ctl <= {wdata[7:6], 6'h00};
      end
      if (wr_irq_en) begin
        irq_en <= {2'b00, wdata[5:4], 4'h0};
      end
      if (wr_alt_0) begin
        alt_sel_0 <= {wdata[7], 7'h00};
      end
      if (wr_alt_1) begin
        alt_sel_1 <= {7'h00, wdata[0]};
      end
    end
  end

  // Two-flop synchronisers for the external clock and data
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      ck_meta <= 2'b00;
      ck_sync <= 2'b00;
      ck_prev <= 1'b0;
      dt_meta <= 2'b00;
      dt_sync <= 2'b00;
    end else begin
      ck_meta <= i_serial_clock_pin;
      ck_sync <= ck_meta;
      ck_prev <= ck_sel;
      dt_meta <= i_serial_data_pin;
      dt_sync <= dt_meta;
    end
  end

  // Receive shifter and FIFO; a cleared port enable resets the receive and transmit paths, not the control registers
  always_ff @(posedge i_core_clk) begin
    if (port_rst) begin // [R7]
      rx_shift <= 9'h000;
      rx_bits <= 4'h0;
      rx_wr_ptr <= '0;
      rx_rd_ptr <= '0;
      rx_count <= '0;
      overrun <= 1'b0;
    end else begin
      if (!rx_mode) begin
        rx_bits <= 4'h0;
      end else if (rx_bit_take) begin // [R10]
        rx_shift <= rx_word;
        rx_bits <= rx_word_done ? 4'h0 : rx_bits + 4'h1;
      end
      if (rx_push) begin
        rx_wr_ptr <= ptr_inc(rx_wr_ptr);
      end
      if (rx_pop) begin
        rx_rd_ptr <= ptr_inc(rx_rd_ptr);
      end
      rx_count <= rx_count + (PTR_W + 1)'(rx_push) - (PTR_W + 1)'(rx_pop);
      // A new overflow in the clearing cycle still wins
      if (rx_overflow) begin
        overrun <= 1'b1; // [R23]
      end else if (!cont_rx) begin
        overrun <= 1'b0; // [R7]
      end
    end
  end

  // FIFO storage needs no reset; the count guards its contents
  always_ff @(posedge i_core_clk) begin
    if (rx_push) begin
      rx_fifo[rx_wr_ptr] <= '{ninth: rx_aligned[8], data: rx_aligned[7:0]};
    end
  end

  // Transmit holding and shift registers
  always_ff @(posedge i_core_clk) begin
    if (port_rst) begin
      tx_hold <= '0;
      tx_hold_valid <= 1'b0;
      tx_hold_long <= 1'b0;
      tx_shift <= 9'h000;
      tx_bits_left <= 4'h0;
      tx_long <= 1'b0;
    end else begin
      if (tx_load_direct) begin // [R22]
        tx_shift <= {tx_wr_word.ninth, tx_wr_word.data};
        tx_bits_left <= tx_wr_long ? ssp_pkg::BITS_LONG_WORD : ssp_pkg::BITS_SHORT_WORD;
        tx_long <= tx_wr_long;
      end else if (tx_load_hold) begin // [R16]
        tx_shift <= {tx_hold.ninth, tx_hold.data};
        tx_bits_left <= tx_hold_long ? ssp_pkg::BITS_LONG_WORD : ssp_pkg::BITS_SHORT_WORD;
        tx_long <= tx_hold_long;
      end else if (tx_bit_step) begin // [R9] [R15]
        tx_shift <= {1'b0, tx_shift[8:1]};
        tx_bits_left <= tx_bits_left - 4'h1;
      end
      // A write in the cycle the holding word moves out refills it
      if (wr_tx_data && !tx_load_direct) begin
        tx_hold <= tx_wr_word;
        tx_hold_long <= tx_wr_long;
        tx_hold_valid <= 1'b1; // [R14] [R18]
      end else if (tx_load_hold) begin
        tx_hold_valid <= 1'b0; // [R16]
      end
    end
  end

  // Data pin drive: only the selected location, only while transmitting
  always_ff @(posedge i_core_clk) begin
    if (port_rst) begin
      o_serial_data_pin <= 2'b00;
      o_serial_data_oe <= 2'b00;
    end else begin
      o_serial_data_pin <= {2{tx_shift[0]}};
      o_serial_data_oe <= tx_mode ? (dt_alt ? 2'b10 : 2'b01) : 2'b00; // [R15] [R19]
    end
  end

  // Wake and vector requests toward the processor
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      o_wake <= 1'b0;
      o_vector_req <= 1'b0;
    end else begin
      o_wake <= i_sleep & irq_req; // [R11] [R17]
      o_vector_req <= ~i_sleep & irq_req & int_ctl[ssp_pkg::ICN_GLOBAL_ENABLE]; // [R13]
    end
  end

  logic unused_ok;
  assign unused_ok = &{1'b0, i_avs_writedata[31:8], i_avs_byteenable[3:1], tx_long};

endmodule

//--- tb/ssp_link_master.sv
`timescale 1ns/1ps
module ssp_link_master (
  // Pin location select
  input wire logic i_clk_alt,
  input wire logic i_dat_alt,
  // Device pins
  input wire logic [1:0] i_data_out,
  output logic [1:0] o_clk,
  output logic [1:0] o_data
);
  logic clk_line = 1'b1;
  logic dat_line = 1'b0;
  // Clock idles high between frames; unused data location is driven with the inverse of the data line
  assign o_clk = i_clk_alt ? {clk_line, 1'b1} : {1'b1, clk_line};
  assign o_data = i_dat_alt ? {dat_line, ~dat_line} : {~dat_line, dat_line};
  // Master drives clock and data, LSB first, data set while the clock is high
  task automatic send_word(input int n, input logic [8:0] w);
    for (int k = 0; k < n; k++) begin
      dat_line = w[k];
      #100 clk_line = 1'b0;
      #100 clk_line = 1'b1;
    end
    #50 dat_line = ~dat_line;
  endtask
  // Master clocks the port and samples its data on each falling edge
  task automatic get_word(input int n, output logic [8:0] w);
    w = 9'h000;
    for (int k = 0; k < n; k++) begin
      #100 clk_line = 1'b0;
      w[k] = i_data_out[i_dat_alt];
      #100 clk_line = 1'b1;
    end
  endtask
endmodule

//--- tb/ssp_serial_port_properties.sv
`timescale 1ns/1ps
module ssp_serial_port_properties #(
  parameter int RX_FIFO_DEPTH = 2
) (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst,
  // Register bus
  input wire logic [5:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  input wire logic [31:0] o_avs_readdata,
  input wire logic o_avs_waitrequest,
  // Processor side
  input wire logic i_sleep,
  input wire logic o_wake,
  input wire logic o_vector_req,
  // Serial pins
  input wire logic [1:0] i_serial_clock_pin,
  input wire logic [1:0] i_serial_data_pin,
  input wire logic [1:0] o_serial_data_pin,
  input wire logic [1:0] o_serial_data_oe
);
  logic [3:0] hi_cnt;
  logic [3:0] wr_cnt;
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (i_rst);
  // A bit may only move after a link clock fall or a bus write, so count quiet cycles
  always_ff @(posedge i_core_clk) begin
    hi_cnt <= (i_rst || !(&i_serial_clock_pin)) ? 4'h0 : hi_cnt + {3'h0, hi_cnt != 4'hF};
    wr_cnt <= (i_rst || i_avs_write) ? 4'h0 : wr_cnt + {3'h0, wr_cnt != 4'hF};
  end
  sequence s_one_wait;
    o_avs_waitrequest ##1 !o_avs_waitrequest;
  endsequence
  a_read_wait: assert property ($rose(i_avs_read) |-> s_one_wait)
    else $error("read not answered after one wait");
  a_write_wait: assert property ($rose(i_avs_write) |-> s_one_wait)
    else $error("write not answered after one wait");
  a_read_upper: assert property (i_avs_read && !o_avs_waitrequest |-> o_avs_readdata[31:8] == 24'h0)
    else $error("read data above the low byte");
  a_wake_asleep: assert property (!i_sleep |=> !o_wake)
    else $error("wake raised while awake");
  a_vector_awake: assert property (i_sleep |=> !o_vector_req)
    else $error("vector requested while asleep");
  a_wake_vec_excl: assert property (!(o_wake && o_vector_req))
    else $error("wake and vector together");
  a_oe_onehot: assert property ($onehot0(o_serial_data_oe))
    else $error("data pin driven at two places");
  a_tx_bit_stands: assert property (hi_cnt > 4'h6 && wr_cnt > 4'h6 && o_serial_data_oe != 2'h0 |=> $stable(o_serial_data_pin))
    else $error("transmit bit moved without a link clock");
endmodule
bind ssp_serial_port ssp_serial_port_properties #(.RX_FIFO_DEPTH(RX_FIFO_DEPTH)) i_props (
  .i_core_clk(i_core_clk), .i_rst(i_rst), .i_avs_address(i_avs_address), .i_avs_read(i_avs_read),
  .i_avs_write(i_avs_write), .i_avs_writedata(i_avs_writedata), .i_avs_byteenable(i_avs_byteenable),
  .o_avs_readdata(o_avs_readdata), .o_avs_waitrequest(o_avs_waitrequest), .i_sleep(i_sleep),
  .o_wake(o_wake), .o_vector_req(o_vector_req), .i_serial_clock_pin(i_serial_clock_pin),
  .i_serial_data_pin(i_serial_data_pin), .o_serial_data_pin(o_serial_data_pin),
  .o_serial_data_oe(o_serial_data_oe));

//--- tb/sync_slave_serial_port_tb.sv
`timescale 1ns/1ps
module sync_slave_serial_port_tb;
  localparam logic [5:0] RXS = ssp_pkg::ADDR_RX_STATUS_CONTROL;
  localparam logic [5:0] RXD = ssp_pkg::ADDR_RECEIVE_DATA;
  localparam logic [5:0] FLG = ssp_pkg::ADDR_PERIPH_IRQ_FLAGS_1;
  localparam logic [5:0] PIE = ssp_pkg::ADDR_PERIPH_IRQ_ENABLE_1;
  localparam logic [5:0] TXH = ssp_pkg::ADDR_TX_HOLDING;
  logic clk;
  logic rst;
  logic [5:0] adr;
  logic rd;
  logic wr;
  logic [31:0] wd;
  logic sleep;
  logic clk_alt;
  logic dat_alt;
  logic [31:0] rdata;
  logic wrq;
  logic [31:0] q;
  logic [1:0] ck_pin;
  logic [1:0] dt_pin;
  logic [1:0] dt_out;
  logic [1:0] dt_oe;
  logic wake;
  logic vec;
  logic [8:0] w;
  int fail_count;
  int checks_done;
  ssp_serial_port #(.RX_FIFO_DEPTH(2)) i_dut (
    .i_core_clk(clk), .i_rst(rst), .i_avs_address(adr), .i_avs_read(rd), .i_avs_write(wr),
    .i_avs_writedata(wd), .i_avs_byteenable(4'hF), .o_avs_readdata(rdata), .o_avs_waitrequest(wrq),
    .i_sleep(sleep), .o_wake(wake), .o_vector_req(vec), .i_serial_clock_pin(ck_pin),
    .i_serial_data_pin(dt_pin), .o_serial_data_pin(dt_out), .o_serial_data_oe(dt_oe));
  ssp_link_master i_master (.i_clk_alt(clk_alt), .i_dat_alt(dat_alt), .i_data_out(dt_out),
    .o_clk(ck_pin), .o_data(dt_pin));
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // Request held until waitrequest is seen low at a rising edge
  task automatic bus(input logic w_en, input logic [5:0] a, input logic [7:0] d);
    logic busy;
    busy = 1'b1;
    wr <= w_en;
    rd <= !w_en;
    adr <= a;
    wd <= {24'h0, d};
    for (int n = 0; n < 20 && busy; n++) begin
      @(posedge clk);
      busy = wrq;
      q = rdata;
    end
    wr <= 1'b0;
    rd <= 1'b0;
    if (busy !== 1'b0) begin
      fail_count++;
      test_done();
    end
    @(posedge clk);
  endtask
  task automatic rchk(input string nm, input logic [5:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h00);
    chk(nm, {24'h0, e}, q);
  endtask
  // Registered flags need the link sync and one update edge
  task automatic settle();
    repeat (8) @(posedge clk);
  endtask
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  initial begin
    rst = 1'b1;
    {rd, wr, adr, wd, sleep, clk_alt, dat_alt} = '0;
    fail_count = 0;
    checks_done = 0;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rchk("rx_status", RXS, 8'h00);
    rchk("flags", FLG, 8'h10);
    rchk("unmapped", 6'h28, 8'h00);
    rchk("tx_holding", TXH, 8'h00);
    // Clock-master select set: nothing may shift during sleep
    bus(1'b1, ssp_pkg::ADDR_TX_STATUS_CONTROL, 8'h90);
    bus(1'b1, RXS, 8'h90);
    sleep <= 1'b1;
    i_master.send_word(8, 9'h0A5);
    settle();
    rchk("flags", FLG, 8'h10);
    chk("wake", 32'h0, {31'h0, wake});
    sleep <= 1'b0;
    bus(1'b1, ssp_pkg::ADDR_TX_STATUS_CONTROL, 8'h10);
    bus(1'b1, RXS, 8'h80);
    bus(1'b1, PIE, 8'h20);
    bus(1'b1, ssp_pkg::ADDR_INTERRUPT_CONTROL, 8'h80);
    rchk("rx_idle", ssp_pkg::ADDR_BAUD_CONTROL, 8'h40);
    i_master.send_word(8, 9'h0A5);
    settle();
    rchk("flags", FLG, 8'h10);
    bus(1'b1, RXS, 8'hB0);
    rchk("rx_idle", ssp_pkg::ADDR_BAUD_CONTROL, 8'h00);
    sleep <= 1'b1;
    i_master.send_word(8, 9'h05A);
    settle();
    chk("wake", 32'h1, {31'h0, wake});
    chk("vector", 32'h0, {31'h0, vec});
    sleep <= 1'b0;
    settle();
    chk("vector", 32'h1, {31'h0, vec});
    rchk("flags", FLG, 8'h30);
    rchk("rx_data", RXD, 8'h5A);
    rchk("flags", FLG, 8'h10);
    bus(1'b1, ssp_pkg::ADDR_ALT_PIN_SELECT_0, 8'h80);
    bus(1'b1, ssp_pkg::ADDR_ALT_PIN_SELECT_1, 8'h01);
    clk_alt <= 1'b1;
    dat_alt <= 1'b1;
    bus(1'b1, RXS, 8'hD0);
    i_master.send_word(9, 9'h1C3);
    settle();
    rchk("rx_status", RXS, 8'hD1);
    bus(1'b1, PIE, 8'h00);
    settle();
    chk("vector", 32'h0, {31'h0, vec});
    rchk("rx_data", RXD, 8'hC3);
    bus(1'b1, ssp_pkg::ADDR_ALT_PIN_SELECT_0, 8'h00);
    bus(1'b1, ssp_pkg::ADDR_ALT_PIN_SELECT_1, 8'h00);
    clk_alt <= 1'b0;
    dat_alt <= 1'b0;
    bus(1'b1, RXS, 8'h90);
    // Three words into a two-deep buffer
    for (int k = 1; k < 4; k++) begin
      i_master.send_word(8, 9'(k * 17));
      settle();
    end
    rchk("rx_status", RXS, 8'h92);
    rchk("rx_data", RXD, 8'h11);
    rchk("rx_data", RXD, 8'h22);
    rchk("flags", FLG, 8'h10);
    bus(1'b1, RXS, 8'h80);
    rchk("rx_status", RXS, 8'h80);
    bus(1'b1, PIE, 8'h10);
    bus(1'b1, ssp_pkg::ADDR_INTERRUPT_CONTROL, 8'h40);
    bus(1'b1, ssp_pkg::ADDR_TX_STATUS_CONTROL, 8'h30);
    bus(1'b1, TXH, 8'h3C);
    rchk("flags", FLG, 8'h10);
    bus(1'b1, TXH, 8'hC3);
    rchk("flags", FLG, 8'h00);
    settle();
    chk("data_oe", 32'h1, {30'h0, dt_oe});
    sleep <= 1'b1;
    settle();
    chk("wake", 32'h0, {31'h0, wake});
    i_master.get_word(8, w);
    chk("tx_word", 32'h3C, {23'h0, w});
    settle();
    chk("wake", 32'h1, {31'h0, wake});
    sleep <= 1'b0;
    bus(1'b1, TXH, 8'h99);
    rchk("flags", FLG, 8'h00);
    i_master.get_word(8, w);
    chk("tx_word", 32'hC3, {23'h0, w});
    i_master.get_word(8, w);
    chk("tx_word", 32'h99, {23'h0, w});
    test_done();
  end
endmodule
